/* src/fts_pkg.sv */
// package of constants and types for the fall-through timing mode select fifo
//
// Contract
// RULE1: select low at master reset gives standard
// RULE2: standard mode empty indicator shows stored words
// RULE3: standard mode full indicator shows free space
// RULE4: standard mode every word needs read request
// RULE5: select high at master reset gives fall-through
// RULE6: fall-through output-valid shows data on bus
// RULE7: fall-through input-space flag shows free space
// RULE8: first word falls through after three edges
// RULE9: later fall-through words advance on read request
// RULE10: host holds select stable after master reset; the bench inverts select once master reset drops
// RULE11: empty indicator low while empty, high after write
// RULE12: output-valid active low, high after last read
// RULE13: read request ignored while buffer empty
// RULE14: mode changes only at next master reset
package fts_pkg;
   localparam int FTS_DATA_W = 36;
   localparam int FTS_DEPTH = 65536;
   // read-side edges from a write into an empty buffer to the word on the bus
   localparam int FTS_FALL_EDGES = 3;
   localparam logic FTS_MODE_RST = 1'b0;
   localparam logic FTS_FLAG_IDLE = 1'b1;

   typedef enum logic {
      FTS_STANDARD,
      FTS_FALL_THROUGH
   } fts_mode_e;

   // all flags active low, as on the pins
   typedef struct packed {
      logic empty_indicator_n;
      logic full_indicator_n;
      logic output_valid_n;
      logic input_space_flag_n;
   } fts_flags_s;
endpackage

/* src/fts_fifo.sv */
// synchronous fifo with standard and fall-through read timing modes
`timescale 1ns/1ps
`default_nettype none
module fts_fifo
   import fts_pkg::*;
#(
   parameter int DATA_W = FTS_DATA_W,
   parameter int DEPTH = FTS_DEPTH
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic master_reset,
   input wire logic fall_through_select,
   input wire logic wr_en,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic rd_en,
   output logic [DATA_W-1:0] output_data_bus,
   output fts_flags_s flags,
   output logic fall_through_mode
);
   localparam int AW = $clog2(DEPTH);

   logic [DATA_W-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] rd_ptr_ff;
   // write pointer seen by the read side, two stages late, so a word
   // reaches the output on the third read edge after its write
   logic [AW:0] wr_vis1_ff;
   logic [AW:0] wr_vis2_ff;
   fts_mode_e mode_ff;
   logic ov_ff;
   logic [DATA_W-1:0] q_ff;
   fts_flags_s flags_ff;

   logic [AW:0] nxt_wr_ptr;
   logic [AW:0] nxt_rd_ptr;
   logic [AW:0] used;
   logic [AW:0] nxt_used;
   logic wr_ok;
   logic rd_avail;
   logic rd_take;
   logic nxt_ov;
   logic nxt_empty;
   logic nxt_full;

   localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
   localparam logic [AW:0] ONE_W = (AW+1)'(1);

   ////////////////////////////////////////////////////////////////////////////
   // pointer arithmetic
   always_comb begin
      used = wr_ptr_ff - rd_ptr_ff;
      wr_ok = wr_en && (used != DEPTH_W);
      rd_avail = (rd_ptr_ff != wr_vis2_ff);
      if (mode_ff == FTS_FALL_THROUGH) begin
         rd_take = rd_avail && (!ov_ff || rd_en); // RULE8 RULE9
      end else begin
         rd_take = rd_avail && rd_en; // RULE4 RULE13
      end
      nxt_wr_ptr = wr_ok ? wr_ptr_ff + ONE_W : wr_ptr_ff;
      nxt_rd_ptr = rd_take ? rd_ptr_ff + ONE_W : rd_ptr_ff;
      nxt_used = nxt_wr_ptr - nxt_rd_ptr;
      // a read with no word left to take clears the output valid
      if (rd_take) begin
         nxt_ov = 1'b1;
      end else if (rd_en) begin
         nxt_ov = 1'b0; // RULE12
      end else begin
         nxt_ov = ov_ff;
      end
      nxt_empty = (nxt_rd_ptr == wr_vis1_ff);
      nxt_full = (nxt_used == DEPTH_W);
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode latch: taken only while master reset is held
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mode_ff <= FTS_STANDARD;
      end else if (master_reset) begin
         mode_ff <= fall_through_select ? FTS_FALL_THROUGH : FTS_STANDARD; // RULE1 RULE5 RULE14
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // storage, no reset so it maps onto block memory
   always_ff @(posedge clk_sys) begin
      if (wr_ok) begin
         mem[wr_ptr_ff[AW-1:0]] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || master_reset) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         wr_vis1_ff <= '0;
         wr_vis2_ff <= '0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         wr_vis1_ff <= wr_ptr_ff;
         wr_vis2_ff <= wr_vis1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output register: holds its word until the next taken read
   always_ff @(posedge clk_sys) begin
      if (srst || master_reset) begin
         q_ff <= '0;
         ov_ff <= 1'b0;
      end else begin
         if (rd_take) begin
            q_ff <= mem[rd_ptr_ff[AW-1:0]]; // RULE4 RULE8 RULE9
         end
         ov_ff <= (mode_ff == FTS_FALL_THROUGH) ? nxt_ov : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags: the pair not used by the current mode idles high
   always_ff @(posedge clk_sys) begin
      if (srst || master_reset) begin
         flags_ff.empty_indicator_n <= 1'b0;
         flags_ff.full_indicator_n <= FTS_FLAG_IDLE;
         flags_ff.output_valid_n <= FTS_FLAG_IDLE;
         flags_ff.input_space_flag_n <= 1'b0;
      end else if (mode_ff == FTS_FALL_THROUGH) begin
         flags_ff.empty_indicator_n <= FTS_FLAG_IDLE;
         flags_ff.full_indicator_n <= FTS_FLAG_IDLE;
         flags_ff.output_valid_n <= !nxt_ov; // RULE6 RULE12
         flags_ff.input_space_flag_n <= nxt_full; // RULE7
      end else begin
         flags_ff.empty_indicator_n <= !nxt_empty; // RULE2 RULE11
         flags_ff.full_indicator_n <= !nxt_full; // RULE3
         flags_ff.output_valid_n <= FTS_FLAG_IDLE;
         flags_ff.input_space_flag_n <= FTS_FLAG_IDLE;
      end
   end

   assign output_data_bus = q_ff;
   assign flags = flags_ff;
   assign fall_through_mode = (mode_ff == FTS_FALL_THROUGH);
endmodule
`default_nettype wire

/* tb/fts_properties.sv */
// port assertions for the fall-through fifo
`timescale 1ns/1ps
`default_nettype none
module fts_properties
   import fts_pkg::*;
#(parameter int DATA_W = 8) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic master_reset,
   input wire logic fall_through_select,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [DATA_W-1:0] output_data_bus,
   input wire fts_flags_s flags,
   input wire logic fall_through_mode
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst || master_reset);
   ////////////////////////////////////////
   mode_latch_a: assert property (disable iff (srst)
      master_reset |=> fall_through_mode == $past(fall_through_select)) else $error("mode not latched");
   mode_hold_a: assert property (1'b1 |=> $stable(fall_through_mode)) else $error("mode moved");
   std_data_a: assert property (!fall_through_mode && !rd_en |=> $stable(output_data_bus)) else $error("std data");
   ft_data_a: assert property (fall_through_mode && !flags.output_valid_n && !rd_en
      |=> $stable(output_data_bus) && !flags.output_valid_n) else $error("ft data");
   std_pair_a: assert property (!fall_through_mode |=> flags.output_valid_n) else $error("std pair");
   ft_pair_a: assert property (fall_through_mode |=> flags.empty_indicator_n && flags.full_indicator_n)
      else $error("ft pair");
   full_stop_a: assert property (!fall_through_mode && !flags.full_indicator_n && !rd_en
      |=> !flags.full_indicator_n) else $error("full lost");
   space_stop_a: assert property (fall_through_mode && flags.input_space_flag_n && !rd_en
      |=> flags.input_space_flag_n) else $error("space lost");
   // writes reach the empty side two edges late, so three quiet cycles cover it; the check asks for four
   empty_hold_a: assert property (!wr_en [*4] ##0 (!fall_through_mode && !flags.empty_indicator_n)
      |=> !flags.empty_indicator_n) else $error("empty lost");
   cover property ($fell(flags.output_valid_n));
   cover property (!flags.full_indicator_n);
   cover property (fall_through_mode && flags.input_space_flag_n);
endmodule
`default_nettype wire

/* tb/fts_host.sv */
// host model driving the fifo write and read ports
`timescale 1ns/1ps
`default_nettype none
module fts_host #(parameter int DATA_W = 8) (
   input wire logic clk_sys,
   input wire logic want_wr,
   input wire logic want_rd,
   input wire logic [DATA_W-1:0] want_data,
   output logic wr_en = 1'b0,
   output logic rd_en = 1'b0,
   output logic [DATA_W-1:0] wr_data = '0
);
   // idle bus inverts its previous value every cycle, so stale data never looks valid
   always @(posedge clk_sys) begin
      wr_en <= want_wr;
      rd_en <= want_rd;
      wr_data <= want_wr ? want_data : ~wr_data;
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the fall-through fifo
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fts_pkg::*;
   localparam int DW = 8;
   localparam int DP = 8;
   logic clk_sys = 1'b0, srst = 1'b1, master_reset = 1'b0, fall_through_select = 1'b0;
   logic want_wr = 1'b0, want_rd = 1'b0, wr_en, rd_en, fall_through_mode;
   logic [DW-1:0] want_data = '0, wr_data, output_data_bus, last;
   logic [DW-1:0] q[$];
   fts_flags_s flags;
   int n_fail = 0, check_count = 0, seed = 33;
   always #2.5 clk_sys = ~clk_sys;
   fts_host #(.DATA_W(DW)) host (.clk_sys, .want_wr, .want_rd, .want_data, .wr_en, .rd_en, .wr_data);
   fts_fifo #(.DATA_W(DW), .DEPTH(DP)) DUT (.clk_sys, .srst, .master_reset, .fall_through_select, .wr_en,
      .wr_data, .rd_en, .output_data_bus, .flags, .fall_through_mode);
   ////////////////////////////////////////
   task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (n_fail == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic op(input logic w, input logic r, input int n);
      want_wr = w;
      want_rd = r;
      want_data = DW'($random(seed));
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // only the pair belonging to the mode is compared
   function automatic logic [DW-1:0] pair(input logic ft, input int n);
      return DW'(ft ? {flags[1:0], n == 0, n > DP} : {flags[3:2], n > 0, n < DP});
   endfunction
   initial begin
      op(0, 0, 4);
      srst = 1'b0;
      for (int m = 0; m < 2; m++) begin
         master_reset = 1'b1;
         fall_through_select = m[0];
         op(0, 0, 2);
         master_reset = 1'b0;
         fall_through_select = ~m[0];
         op(0, 1, 4);
         check(DW'(fall_through_mode), DW'(m[0]));
         check(output_data_bus, '0);
         check(pair(m[0], 0) >> 2, pair(m[0], 0) & 8'h03);
         op(1, 0, 1);
         q.push_back(want_data);
         op(0, 0, 3);
         // the empty indicator sees a write one edge before a word can fall through
         check(pair(m[0], int'(!m[0])) >> 2, pair(m[0], int'(!m[0])) & 8'h03);
         op(0, 0, 1);
         check(pair(m[0], 1) >> 2, pair(m[0], 1) & 8'h03);
         check(output_data_bus, m[0] ? q[0] : '0);
         for (int i = 0; i < DP + 1; i++) begin
            op(1, 0, 1);
            if (q.size() < DP + m) q.push_back(want_data);
         end
         op(0, 0, 4);
         check(pair(m[0], DP + m) >> 2, pair(m[0], DP + m) & 8'h03);
         for (int i = 0; i <= DP + m; i++) begin
            op(0, 1, 1);
            op(0, 0, 4);
            if (q.size() > 0) last = q.pop_front();
            if (m == 0 || q.size() > 0) check(output_data_bus, m[0] ? q[0] : last);
            check(pair(m[0], q.size()) >> 2, pair(m[0], q.size()) & 8'h03);
         end
      end
      complete_run();
   end
   initial begin
      #10000;
      n_fail++;
      complete_run();
   end
endmodule
bind fts_fifo fts_properties #(.DATA_W(DATA_W)) chk (.clk_sys, .srst, .master_reset, .fall_through_select,
   .wr_en, .rd_en, .output_data_bus, .flags, .fall_through_mode);
`default_nettype wire
